// [hdl/irq_deactivation_state_machine.sv]
// per-interrupt lifecycle with completion and deactivation handling
//
// Summary of operation
// - hold active state until explicitly deactivated
// - split bit 0: completion also deactivates
// - split bit 1: completion drops priority only
// - deactivate writes accepted in any order
// - deactivate of inactive interrupt ignored, error
// - completion group must match interrupt group
// - split bit chosen by level and security
// - two states: non-secure deactivates non-secure group1
// - one state: deactivate acts like secure write
// - top level always; secure low obeys routing
// - non-secure low obeys group and routing bits
// - separate four-state machine per interrupt
// - active-and-pending never signalled
// - local message acks hold priority only
// - pending set when raised and forwarding enabled
// - pending cleared by level drop or software
// - edge acknowledge moves pending to active
// - level acknowledge moves to active-and-pending
// - deactivation removes active state
// - extended private ids 1056-1119, not legacy
// - valid write names supported non-special id
// - security disable selects one or two states
`timescale 1ns/100ps
module irq_deactivation_state_machine
  import irq_lifecycle_pkg::*;
#(
  parameter int NUM_BASE = 32,
  parameter bit EXT_PRIVATE = 1'b1,
  parameter bit HAVE_TOP = 1'b1,
  parameter bit SINGLE_SEC = 1'b0,
  parameter bit SYS_ERR_EN = 1'b1,
  parameter int TOTAL = NUM_BASE + (EXT_PRIVATE ? EXT_COUNT : 0)
) (
  input wire logic clk,
  input wire logic sys_rst,
  // interrupt configuration from the distributor
  input wire logic [TOTAL-1:0] levelCfg,
  input wire logic [TOTAL-1:0] groupG1,
  input wire logic [TOTAL-1:0] groupNs,
  input wire logic fwdEnable,
  input wire logic legacyMode,
  // level sources from pins
  input wire logic [TOTAL-1:0] levelIn,
  // edge raise and software pending control
  input wire logic raiseValid,
  input wire logic [ID_W-1:0] raiseId,
  input wire logic swSetValid,
  input wire logic swClrValid,
  input wire logic [ID_W-1:0] swPendId,
  // acknowledge, completion and deactivate accesses
  input wire logic ackValid,
  input wire logic [ID_W-1:0] ackId,
  input wire logic ackLocal,
  input wire logic eoiValid,
  input wire logic eoiGrp1,
  input wire logic eoiLocal,
  input wire logic [ID_W-1:0] eoiId,
  input wire logic dirValid,
  input wire logic [ID_W-1:0] dirId,
  // processing element context and mode bits
  input wire logic atTop,
  input wire logic isSecure,
  input wire logic secure_hyp_enable,
  input wire logic sysreg_iface_enable_top,
  input wire logic security_disable,
  input wire logic irq_trap_route,
  input wire logic fiq_trap_route,
  input wire logic split_eoi_el1,
  input wire logic split_eoi_top,
  input wire logic split_eoi_secure_low,
  input wire logic split_eoi_nonsecure_low,
  // state and status
  output logic [TOTAL-1:0] pendingOut,
  output logic [TOTAL-1:0] activeOut,
  output logic [TOTAL-1:0] signalOut,
  output logic sysError,
  output logic [DEPTH_W-1:0] prioDepth,
  output logic ext_private_range_field,
  output logic singleSecState
);

  localparam int IW = $clog2(TOTAL);
  ////////////////////////////////////////////////////////////////////////////
  // identifier decoding
  // supported, non-special identifier
  function automatic logic idOk(input logic [ID_W-1:0] id, input logic legacy);
    idOk = 1'b0;
    if (id >= SPECIAL_FIRST && id <= SPECIAL_LAST) begin
      idOk = 1'b0;
    end else if (id < NUM_BASE) begin
      idOk = 1'b1;
    end else if (EXT_PRIVATE && !legacy && id >= EXT_FIRST && id <= EXT_LAST) begin
      idOk = 1'b1;
    end
  endfunction

  // identifier to local state index, only meaningful when idOk holds
  function automatic logic [IW-1:0] idIdx(input logic [ID_W-1:0] id);
    if (id < NUM_BASE) begin
      idIdx = id[IW-1:0];
    end else begin
      idIdx = IW'(NUM_BASE + int'(id - EXT_FIRST));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // level synchroniser
  logic [TOTAL-1:0] levelMeta; // first stage, read by second stage only
  logic [TOTAL-1:0] levelSync; // safe level

  // two flops because the sources are asynchronous pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      levelMeta <= '0;
      levelSync <= '0;
    end else begin
      levelMeta <= levelIn;
      levelSync <= levelMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access qualification
  irq_state_t stateArr [TOTAL];
  irq_state_t next_stateArr [TOTAL];

  logic raiseOk, swOk, ackOk, eoiOk, dirOk;
  logic [IW-1:0] raiseIdx, swIdx, ackIdx, eoiIdx, dirIdx;
  logic splitNow; // split mode in force
  logic singleSec; // one security state in effect
  logic dirActive; // deactivate target is active
  logic dirAllowed; // security and routing permit it
  logic ackDo, eoiDo, dirDo;

  assign raiseOk = idOk(raiseId, legacyMode);
  assign swOk = idOk(swPendId, legacyMode);
  assign ackOk = idOk(ackId, legacyMode);
  assign eoiOk = idOk(eoiId, legacyMode);
  assign dirOk = idOk(dirId, legacyMode);
  assign raiseIdx = idIdx(raiseId);
  assign swIdx = idIdx(swPendId);
  assign ackIdx = idIdx(ackId);
  assign eoiIdx = idIdx(eoiId);
  assign dirIdx = idIdx(dirId);
  assign singleSec = SINGLE_SEC || security_disable;

  // split bit selection by level and security state
  always_comb begin
    if (HAVE_TOP) begin
      if (atTop && sysreg_iface_enable_top) begin
        splitNow = split_eoi_top;
      end else if (isSecure) begin
        splitNow = split_eoi_secure_low;
      end else begin
        splitNow = split_eoi_nonsecure_low;
      end
    end else begin
      splitNow = split_eoi_el1;
    end
  end

  // permission of a deactivate write by level, security and routing
  always_comb begin
    dirAllowed = 1'b0;
    if (HAVE_TOP && atTop) begin
      dirAllowed = 1'b1;
    end else if (isSecure || SINGLE_SEC) begin
      // secure low levels; a one-state system behaves the same way
      dirAllowed = groupG1[dirIdx] ? !irq_trap_route : !fiq_trap_route;
    end else if (!singleSec) begin
      // non-secure with two states: only non-secure group 1
      dirAllowed = groupG1[dirIdx] && groupNs[dirIdx] && !irq_trap_route;
    end else begin
      dirAllowed = groupG1[dirIdx] ? !irq_trap_route : !fiq_trap_route;
    end
  end

  // secure hyp level is folded into isSecure by the caller
  logic unusedHyp;
  assign unusedHyp = secure_hyp_enable;

  assign dirActive = dirOk &&
    (stateArr[dirIdx] == ST_ACTIVE || stateArr[dirIdx] == ST_ACT_PEND);
  // only a pending interrupt can be acknowledged; act-pend is never signalled
  assign ackDo = ackValid && ackOk && stateArr[ackIdx] == ST_PENDING;
  // combined drop and deactivate, group must match
  assign eoiDo = eoiValid && eoiOk && !splitNow && (eoiGrp1 == groupG1[eoiIdx]) &&
    (stateArr[eoiIdx] == ST_ACTIVE || stateArr[eoiIdx] == ST_ACT_PEND);
  // deactivate writes in non-split mode are ignored, no ordering kept
  assign dirDo = dirValid && splitNow && dirActive && dirAllowed;

  ////////////////////////////////////////////////////////////////////////////
  // per-interrupt transitions
  always_comb begin
    for (int i = 0; i < TOTAL; i++) begin
      logic setEv, clrEv, ackEv, deactEv;
      setEv = fwdEnable && (
        (raiseValid && raiseOk && raiseIdx == IW'(i) && !levelCfg[i]) ||
        (swSetValid && swOk && swIdx == IW'(i)) ||
        (levelCfg[i] && levelSync[i]));
      clrEv = (levelCfg[i] && !levelSync[i]) ||
        (swClrValid && swOk && swIdx == IW'(i));
      ackEv = ackDo && ackIdx == IW'(i);
      deactEv = (eoiDo && eoiIdx == IW'(i)) || (dirDo && dirIdx == IW'(i));
      next_stateArr[i] = stateArr[i];
      case (stateArr[i])
        ST_INACTIVE: begin
          if (setEv) begin
            next_stateArr[i] = ST_PENDING;
          end
        end
        ST_PENDING: begin
          if (ackEv) begin
            // a still-high level stays pending behind the active state
            next_stateArr[i] = (levelCfg[i] && levelSync[i]) ? ST_ACT_PEND
                                                              : ST_ACTIVE;
          end else if (clrEv && !setEv) begin
            next_stateArr[i] = ST_INACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (deactEv) begin
            next_stateArr[i] = setEv ? ST_PENDING : ST_INACTIVE;
          end else if (setEv) begin
            next_stateArr[i] = ST_ACT_PEND;
          end
        end
        ST_ACT_PEND: begin
          if (deactEv) begin
            next_stateArr[i] = (clrEv && !setEv) ? ST_INACTIVE : ST_PENDING;
          end else if (clrEv && !setEv) begin
            next_stateArr[i] = ST_ACTIVE;
          end
        end
        default: begin
          next_stateArr[i] = ST_INACTIVE;
        end
      endcase
    end
  end

  // state array and registered views of it
  always_ff @(posedge clk) begin
    for (int i = 0; i < TOTAL; i++) begin
      if (sys_rst) begin
        stateArr[i] <= ST_INACTIVE;
        pendingOut[i] <= 1'b0;
        activeOut[i] <= 1'b0;
        signalOut[i] <= 1'b0;
      end else begin
        stateArr[i] <= next_stateArr[i];
        pendingOut[i] <= next_stateArr[i] == ST_PENDING || next_stateArr[i] == ST_ACT_PEND;
        activeOut[i] <= next_stateArr[i] == ST_ACTIVE || next_stateArr[i] == ST_ACT_PEND;
        signalOut[i] <= next_stateArr[i] == ST_PENDING;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  // error pulse on deactivate of an interrupt that is not active
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sysError <= 1'b0;
    end else begin
      sysError <= SYS_ERR_EN && dirValid && dirOk && splitNow && !dirActive;
    end
  end

  // active priority depth; local message acks occupy a level too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prioDepth <= '0;
    end else if ((ackDo || ackLocal) && !(eoiValid && (eoiOk || eoiLocal))) begin
      if (prioDepth != DEPTH_MAX) begin
        prioDepth <= prioDepth + 8'h01;
      end
    end else if (!(ackDo || ackLocal) && eoiValid && (eoiOk || eoiLocal)) begin
      if (prioDepth != 8'h00) begin
        prioDepth <= prioDepth - 8'h01;
      end
    end
  end

  // configuration reporting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_private_range_field <= 1'b0;
      singleSecState <= 1'b0;
    end else begin
      ext_private_range_field <= EXT_PRIVATE && !legacyMode;
      singleSecState <= singleSec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_no_signal_active;
    @(posedge clk) disable iff (sys_rst) (signalOut & activeOut) == '0;
  endproperty
  a_no_signal_active: assert property (p_no_signal_active)
    else $error("active interrupt signalled");
  property p_special_ignored;
    @(posedge clk) disable iff (sys_rst)
      dirValid && dirId >= SPECIAL_FIRST && dirId <= SPECIAL_LAST |-> !dirDo ##1 !sysError;
  endproperty
  a_special_ignored: assert property (p_special_ignored)
    else $error("special identifier acted upon");
  property p_dir_nosplit;
    @(posedge clk) disable iff (sys_rst) dirValid && !splitNow |=> !sysError;
  endproperty
  a_dir_nosplit: assert property (p_dir_nosplit)
    else $error("deactivate in combined mode reacted");
  property p_dir_inactive_err;
    @(posedge clk) disable iff (sys_rst)
      dirValid && dirOk && splitNow && !dirActive |=> sysError == SYS_ERR_EN;
  endproperty
  a_dir_inactive_err: assert property (p_dir_inactive_err)
    else $error("no error on inactive deactivate");
  property p_eoi_deact;
    @(posedge clk) disable iff (sys_rst) eoiDo |=> !activeOut[$past(eoiIdx)];
  endproperty
  a_eoi_deact: assert property (p_eoi_deact)
    else $error("completion did not deactivate");
  property p_split_keeps;
    @(posedge clk) disable iff (sys_rst)
      eoiValid && eoiOk && splitNow && activeOut[eoiIdx] && !(dirDo && dirIdx == eoiIdx)
      |=> activeOut[$past(eoiIdx)];
  endproperty
  a_split_keeps: assert property (p_split_keeps)
    else $error("split completion deactivated");
  property p_ack_edge;
    @(posedge clk) disable iff (sys_rst)
      ackDo && !levelCfg[ackIdx] |=> activeOut[$past(ackIdx)] && !pendingOut[$past(ackIdx)];
  endproperty
  a_ack_edge: assert property (p_ack_edge)
    else $error("edge acknowledge not active");
  property p_ack_level;
    @(posedge clk) disable iff (sys_rst)
      ackDo && levelCfg[ackIdx] && levelSync[ackIdx]
      |=> activeOut[$past(ackIdx)] && pendingOut[$past(ackIdx)];
  endproperty
  a_ack_level: assert property (p_ack_level)
    else $error("level acknowledge not active-pending");
  property p_ns_block;
    @(posedge clk) disable iff (sys_rst)
      dirValid && !atTop && !isSecure && !singleSec && !SINGLE_SEC &&
      !(groupG1[dirIdx] && groupNs[dirIdx]) |-> !dirDo;
  endproperty
  a_ns_block: assert property (p_ns_block)
    else $error("non-secure deactivated secure interrupt");
  property p_top_mode;
    @(posedge clk) disable iff (sys_rst)
      HAVE_TOP && atTop && sysreg_iface_enable_top |-> splitNow == split_eoi_top;
  endproperty
  a_top_mode: assert property (p_top_mode)
    else $error("wrong split bit at top level");
  c_edge_cycle: cover property (@(posedge clk) disable iff (sys_rst) ackDo ##[1:20] eoiDo);
  c_split_dir: cover property (@(posedge clk) disable iff (sys_rst) dirDo);
  c_error: cover property (@(posedge clk) disable iff (sys_rst) sysError);
  c_act_pend: cover property (@(posedge clk) disable iff (sys_rst)
    (activeOut & pendingOut) != '0);
endmodule

// [inc/irq_lifecycle_pkg.sv]
// shared constants and types for the interrupt lifecycle block
package irq_lifecycle_pkg;

  // identifier width, wide enough for every architected identifier
  localparam int ID_W = 13;
  // special identifiers that never name a real interrupt
  localparam logic [12:0] SPECIAL_FIRST = 13'h03FC;
  localparam logic [12:0] SPECIAL_LAST = 13'h03FF;
  // optional extended private range, 1056 to 1119
  localparam logic [12:0] EXT_FIRST = 13'h0420;
  localparam logic [12:0] EXT_LAST = 13'h045F;
  localparam int EXT_COUNT = 64;
  // width of the active priority depth counter
  localparam int DEPTH_W = 8;
  localparam logic [7:0] DEPTH_MAX = 8'hFF;

  // per-interrupt lifecycle, one-hot
  typedef enum logic [3:0] {
    ST_INACTIVE = 4'h1,
    ST_PENDING = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_ACT_PEND = 4'h8
  } irq_state_t;

endpackage

// [sim/pe_model.sv]
// processing element model: acknowledge, completion and deactivate accesses
`timescale 1ns/100ps
module pe_model
  import irq_lifecycle_pkg::*;
(
  input wire logic clk,
  output logic ackValid,
  output logic ackLocal,
  output logic [ID_W-1:0] ackId,
  output logic eoiValid,
  output logic eoiGrp1,
  output logic eoiLocal,
  output logic [ID_W-1:0] eoiId,
  output logic dirValid,
  output logic [ID_W-1:0] dirId
);
  // one element only, so whoever activated an interrupt deactivates it too
  initial begin
    {ackValid, ackLocal, eoiValid, eoiGrp1, eoiLocal, dirValid} = 6'h00;
    ackId = '0;
    eoiId = '0;
    dirId = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // k: 0 acknowledge, 1 completion, 2 deactivate; one-cycle pulse
  // deactivates follow their completion unless the bench asks for a stray one
  task automatic acc(input int k, input logic [ID_W-1:0] id, input logic g,
                     input logic loc);
    @(negedge clk);
    ackValid = (k == 0);
    eoiValid = (k == 1);
    dirValid = (k == 2);
    ackLocal = loc && (k == 0);
    eoiLocal = loc && (k == 1);
    eoiGrp1 = g;
    ackId = id;
    eoiId = id;
    dirId = id;
    @(negedge clk);
    {ackValid, ackLocal, eoiValid, eoiLocal, dirValid} = 5'h00;
    // released id lines must not keep showing the last value
    ackId = ~id;
    eoiId = ~id;
    dirId = ~id;
    @(negedge clk);
  endtask
endmodule

// [sim/test_irq_deactivation_state_machine.sv]
// self-checking bench for the interrupt lifecycle block
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin badCount++; \
  $display("mismatch %s expected %0h seen %0h", n, e, a); end end
module test_irq_deactivation_state_machine
  import irq_lifecycle_pkg::*;
;
  localparam int T = 96;
  logic clk, sys_rst, fwdEnable, legacyMode, raiseValid, swSetValid, swClrValid;
  logic atTop, isSecure, sysreg_iface_enable_top, security_disable, irq_trap_route;
  logic fiq_trap_route, split_eoi_el1, split_eoi_top, split_eoi_secure_low;
  logic split_eoi_nonsecure_low, ackValid, ackLocal, eoiValid, eoiGrp1, eoiLocal;
  logic dirValid, sysError, ext_private_range_field, singleSecState;
  logic [T-1:0] levelCfg, groupG1, groupNs, levelIn, pendingOut, activeOut, signalOut;
  logic [ID_W-1:0] raiseId, swPendId, ackId, eoiId, dirId;
  logic [DEPTH_W-1:0] prioDepth;
  int badCount = 0, checked = 0, errCount = 0, cycles = 0, e;

  irq_deactivation_state_machine DUT (.clk, .sys_rst, .levelCfg, .groupG1, .groupNs,
    .fwdEnable, .legacyMode, .levelIn, .raiseValid, .raiseId, .swSetValid, .swClrValid,
    .swPendId, .ackValid, .ackId, .ackLocal, .eoiValid, .eoiGrp1, .eoiLocal, .eoiId,
    .dirValid, .dirId, .atTop, .isSecure, .secure_hyp_enable(1'b0),
    .sysreg_iface_enable_top, .security_disable, .irq_trap_route, .fiq_trap_route,
    .split_eoi_el1, .split_eoi_top, .split_eoi_secure_low, .split_eoi_nonsecure_low,
    .pendingOut, .activeOut, .signalOut, .sysError, .prioDepth,
    .ext_private_range_field, .singleSecState);
  pe_model pe (.clk, .ackValid, .ackLocal, .ackId, .eoiValid, .eoiGrp1, .eoiLocal,
    .eoiId, .dirValid, .dirId);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counts error pulses, which last one cycle, and cuts a hang short;
  // sampled at the falling edge so the pulse is settled, not just launched
  always @(negedge clk) begin
    cycles++;
    if (sysError === 1'b1)
      errCount++;
    if (cycles == 3000) begin
      badCount++;
      wrapUp();
    end
  end
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // source pulse: 0 edge raise, 1 software set, 2 software clear
  task automatic src(input int k, input logic [ID_W-1:0] id);
    @(negedge clk);
    raiseValid = (k == 0);
    swSetValid = (k == 1);
    swClrValid = (k == 2);
    raiseId = id;
    swPendId = id;
    @(negedge clk);
    {raiseValid, swSetValid, swClrValid} = 3'h0;
    @(negedge clk);
  endtask
  // pending, active, signalled of one interrupt index
  task automatic st(input int i, input logic [2:0] x);
    `CHK("state", x, {pendingOut[i], activeOut[i], signalOut[i]})
  endtask
  task automatic act(input logic [ID_W-1:0] id, input logic g);
    src(0, id);
    pe.acc(0, id, 1'b0, 1'b0);
    pe.acc(1, id, g, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tEdge();
    src(0, 13'h0005);
    st(5, 3'b101);
    pe.acc(0, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b010);
    pe.acc(1, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b000);
    `CHK("depth", 8'h00, prioDepth)
  endtask
  task automatic tGroup();
    src(0, 13'h0006);
    pe.acc(0, 13'h0006, 1'b0, 1'b0);
    pe.acc(1, 13'h0006, 1'b0, 1'b0);
    st(6, 3'b010);
    pe.acc(1, 13'h0006, 1'b1, 1'b0);
    st(6, 3'b000);
  endtask
  task automatic tSw();
    src(1, 13'h0009);
    st(9, 3'b101);
    src(2, 13'h0009);
    st(9, 3'b000);
    fwdEnable = 1'b0;
    src(0, 13'h0009);
    st(9, 3'b000);
    fwdEnable = 1'b1;
  endtask
  // split mode: completions in reverse, deactivates in acknowledge order
  task automatic tSplit();
    split_eoi_secure_low = 1'b1;
    src(0, 13'h0005);
    src(0, 13'h0006);
    pe.acc(0, 13'h0005, 1'b0, 1'b0);
    pe.acc(0, 13'h0006, 1'b0, 1'b0);
    pe.acc(1, 13'h0006, 1'b1, 1'b0);
    pe.acc(1, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b010);
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b000);
    st(6, 3'b010);
    pe.acc(2, 13'h0006, 1'b0, 1'b0);
    st(6, 3'b000);
    e = errCount;
    pe.acc(2, 13'h0007, 1'b0, 1'b0);
    `CHK("error pulses", e + 1, errCount)
    st(7, 3'b000);
    // a special identifier is no valid write: no action and no error pulse
    pe.acc(2, 13'h03FC, 1'b0, 1'b0);
    `CHK("error pulses", e + 1, errCount)
  endtask
  task automatic tLevel();
    levelIn[8] = 1'b1;
    repeat (4) @(negedge clk);
    st(8, 3'b101);
    pe.acc(0, 13'h0008, 1'b0, 1'b0);
    st(8, 3'b110);
    pe.acc(1, 13'h0008, 1'b0, 1'b0);
    pe.acc(2, 13'h0008, 1'b0, 1'b0);
    st(8, 3'b101);
    levelIn[8] = 1'b0;
    repeat (4) @(negedge clk);
    st(8, 3'b000);
  endtask
  task automatic tSec();
    isSecure = 1'b0;
    split_eoi_nonsecure_low = 1'b1;
    act(13'h0005, 1'b0);
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b010);
    act(13'h0006, 1'b1);
    pe.acc(2, 13'h0006, 1'b0, 1'b0);
    st(6, 3'b000);
    isSecure = 1'b1;
    fiq_trap_route = 1'b1;
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b010);
    {atTop, sysreg_iface_enable_top, split_eoi_top, split_eoi_secure_low} = 4'hE;
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b000);
    act(13'h0005, 1'b0);
    st(5, 3'b010);
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    {atTop, sysreg_iface_enable_top, split_eoi_top, fiq_trap_route} = 4'h0;
  endtask
  task automatic tDs();
    security_disable = 1'b1;
    isSecure = 1'b0;
    @(negedge clk);
    `CHK("single state", 1'b1, singleSecState)
    act(13'h0005, 1'b0);
    pe.acc(2, 13'h0005, 1'b0, 1'b0);
    st(5, 3'b000);
    act(13'h0006, 1'b1);
    irq_trap_route = 1'b1;
    pe.acc(2, 13'h0006, 1'b0, 1'b0);
    st(6, 3'b010);
    irq_trap_route = 1'b0;
    pe.acc(2, 13'h0006, 1'b0, 1'b0);
    st(6, 3'b000);
    {security_disable, isSecure} = 2'h1;
  endtask
  task automatic tExt();
    src(0, 13'h0420);
    st(32, 3'b101);
    src(2, 13'h0420);
    src(0, 13'h03FC);
    `CHK("pending", {T{1'b0}}, pendingOut)
    legacyMode = 1'b1;
    src(0, 13'h0421);
    st(33, 3'b000);
    `CHK("ext range", 1'b0, ext_private_range_field)
    pe.acc(0, 13'h1FFF, 1'b0, 1'b1);
    `CHK("depth", 8'h01, prioDepth)
    pe.acc(1, 13'h1FFF, 1'b0, 1'b1);
    `CHK("depth", 8'h00, prioDepth)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    {fwdEnable, isSecure, legacyMode, raiseValid, swSetValid, swClrValid} = 6'h30;
    {atTop, sysreg_iface_enable_top, security_disable, irq_trap_route} = 4'h0;
    {fiq_trap_route, split_eoi_el1, split_eoi_top, split_eoi_secure_low} = 4'h0;
    split_eoi_nonsecure_low = 1'b0;
    levelCfg = 96'h100;
    groupG1 = 96'h40;
    groupNs = 96'h40;
    levelIn = '0;
    raiseId = '0;
    swPendId = '0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK("pending", {T{1'b0}}, pendingOut)
    `CHK("ext range", 1'b1, ext_private_range_field)
    tEdge();
    tGroup();
    tSw();
    tSplit();
    tLevel();
    tSec();
    tDs();
    tExt();
    wrapUp();
  end
endmodule
